// ===== inc/wdw_pkg.sv
package wdw_pkg;
  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CLK_PERIOD_NS = 8;

  // Register indices; byte address is four times the index
  localparam logic [2:0] IDX_CONTROL = 3'h0;
  localparam logic [2:0] IDX_STATUS = 3'h1;
  localparam logic [2:0] IDX_EVENT = 3'h2;
  localparam logic [2:0] IDX_MASK = 3'h3;
  localparam logic [2:0] IDX_UNLOCK = 3'h4;
  localparam int IDX_LSB = 2;

  // Field positions and reset values
  localparam int STATUS_LOCK_BIT = 7;
  localparam int STATUS_BUSY_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int WIN_MSB = 7;
  localparam int WIN_LSB = 4;
  localparam int PER_MSB = 3;
  localparam int PER_LSB = 0;

  // Interrupt events
  localparam int EV_W = 3;
  localparam int EV_TIMEOUT = 0;
  localparam int EV_EARLY = 1;
  localparam int EV_SYNCED = 2;

  // Unlock key value is arbitrary
  localparam logic [7:0] UNLOCK_KEY = 8'h5a;
  localparam int UNLOCK_SPAN = 4;

  // Counts
  localparam int SYNC_TICKS = 2;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] CODE_MAX = 4'hb;
  localparam int CODE_SHIFT = 2;
  localparam int CNT_W = 15;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } wdw_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } wdw_axi_rsp_t;

  // Codes 1..11 give 2^(n+2) ticks; reserved codes give zero
  function automatic logic [CNT_W-1:0] code_cycles(input logic [3:0] code);
    if (code == CODE_OFF || code > CODE_MAX) begin
      return '0;
    end
    return CNT_W'(1) << (code + 4'(CODE_SHIFT));
  endfunction
endpackage

// ===== verilog/wdw_sync.sv
`timescale 1ns/1ps
module wdw_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import wdw_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } wdw_sync_st_t;

  wdw_sync_st_t st;
  wdw_sync_st_t next_st;

  if (WIDTH < 1) begin : g_chk
    $error("wdw_sync width must be at least one");
  end

  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule

// ===== verilog/wdw_unlock.sv
`timescale 1ns/1ps
module wdw_unlock #(
  parameter int SPAN = wdw_pkg::UNLOCK_SPAN
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write events
  input wire logic key_write,
  input wire logic bus_write,
  input wire logic consume,
  // Window state
  output logic unlock_open
);
  import wdw_pkg::*;

  localparam int LW = $clog2(SPAN + 1);

  typedef struct packed {
    logic [LW-1:0] left;
    logic open;
  } wdw_unlock_st_t;

  wdw_unlock_st_t st;
  wdw_unlock_st_t next_st;

  if (SPAN < 1 || SPAN > 15) begin : g_chk
    $error("wdw_unlock span out of range");
  end

  // Key opens a window of SPAN further writes; any protected write closes it
  always_comb begin
    next_st = st;
    if (key_write) begin
      next_st.left = LW'(SPAN);
    end else if (consume) begin
      next_st.left = '0;
    end else if (bus_write && st.left != '0) begin
      next_st.left = st.left - LW'(1);
    end
    next_st.open = (next_st.left != '0);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign unlock_open = st.open;
endmodule

// ===== verilog/wdw_watchdog_top.sv
`timescale 1ns/1ps
// How it works
// - Upper nibble code 1 to 11 selects windowed mode
// - Code n (1 to 11) gives 2^(n+2) ticks; other codes give zero
// - Lower nibble code 1 to 11 enables, sets time-out
// - In window mode lower nibble sets open
// - Lock set makes control register read-only
// - Lock writable to one; zero only debug
// - Nonzero boot period sets lock automatically
// - Status register resets to all zeros
// - Busy rises after every accepted control write
// - Busy clears when transfer completes
// - Lock write needs preceding unlock sequence
// - Busy flag is read-only, unprotected
// - Software avoids control writes while busy
// - Protected write only within four after key
// - Missing restart before time-out resets system
// - Early restart in closed period resets
module wdw_watchdog_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus
  input wire wdw_pkg::wdw_axi_req_t axi_req,
  output wdw_pkg::wdw_axi_rsp_t axi_rsp,
  // Pins
  input wire logic [7:0] boot_config_byte,
  input wire logic low_power_osc,
  input wire logic debug_mode,
  input wire logic watchdog_restart_instr,
  // Outputs
  output logic system_reset_req,
  output logic irq
);
  import wdw_pkg::*;

  typedef struct packed {
    wdw_axi_rsp_t rsp;
    logic aw_ok;
    logic w_ok;
    logic [ADDR_W-1:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic [7:0] control;
    logic lock;
    logic busy;
    logic [1:0] sync_cnt;
    logic [3:0] act_win;
    logic [3:0] act_per;
    logic armed;
    logic [CNT_W-1:0] cnt;
    logic osc_prev;
    logic [1:0] boot_wait;
    logic boot_done;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] mask;
    logic irq;
    logic rst_req;
  } wdw_state_t;

  wdw_state_t st;
  wdw_state_t next_st;

  logic [9:0] sync_out;
  logic osc_s;
  logic debug_s;
  logic [7:0] boot_s;
  logic unlock_open;
  logic wr_fire;
  logic wsel;
  logic [2:0] widx;
  logic key_wr;
  logic consume;
  logic ctrl_accept;
  logic tick;
  logic run;
  logic early;
  logic timeout;
  logic [CNT_W-1:0] closed_len;
  logic [CNT_W-1:0] open_len;
  logic [CNT_W-1:0] total_len;

  function automatic logic [DATA_W-1:0] read_word(input wdw_state_t s, input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_CONTROL: v = s.control;
      IDX_STATUS: begin
        v[STATUS_LOCK_BIT] = s.lock;
        v[STATUS_BUSY_BIT] = s.busy;
      end
      IDX_EVENT: v[EV_W-1:0] = s.ev;
      IDX_MASK: v[EV_W-1:0] = s.mask;
      default: v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  function automatic logic mapped(input logic [2:0] idx);
    return idx <= IDX_UNLOCK;
  endfunction

  // Oscillator, debug and strap are foreign to this clock
  wdw_sync #(
    .WIDTH(10)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({boot_config_byte, debug_mode, low_power_osc}),
    .sync_out(sync_out)
  );

  assign osc_s = sync_out[0];
  assign debug_s = sync_out[1];
  assign boot_s = sync_out[9:2];

  wdw_unlock #(
    .SPAN(UNLOCK_SPAN)
  ) u_unlock (
    .sys_clk(sys_clk),
    .rst(rst),
    .key_write(key_wr),
    .bus_write(wr_fire),
    .consume(consume),
    .unlock_open(unlock_open)
  );

  assign widx = st.awaddr[IDX_LSB+2:IDX_LSB];
  assign wr_fire = st.aw_ok && st.w_ok && !st.rsp.bvalid;
  assign wsel = wr_fire && st.wstrb0 && st.boot_done;
  assign key_wr = wsel && widx == IDX_UNLOCK && st.wdata == UNLOCK_KEY;
  assign consume = wsel && (widx == IDX_CONTROL || widx == IDX_STATUS);
  // Refused when locked, busy, or not unlocked
  assign ctrl_accept = wsel && widx == IDX_CONTROL && unlock_open && !st.lock && !st.busy;
  assign tick = osc_s && !st.osc_prev;

  // Window only counts once armed by a restart
  assign closed_len = st.armed ? code_cycles(st.act_win) : '0;
  assign open_len = code_cycles(st.act_per);
  assign total_len = closed_len + open_len;
  assign run = open_len != '0 && !debug_s && !st.rst_req;
  assign early = run && watchdog_restart_instr && st.armed && st.cnt < closed_len;
  assign timeout = run && !watchdog_restart_instr && tick && CNT_W'(st.cnt + 1'b1) >= total_len;

  always_comb begin
    next_st = st;
    next_st.osc_prev = osc_s;
    if (axi_req.awvalid && st.rsp.awready) begin
      next_st.aw_ok = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st.rsp.wready) begin
      next_st.w_ok = 1'b1;
      next_st.wdata = axi_req.wdata[7:0];
      next_st.wstrb0 = axi_req.wstrb[0];
    end
    if (st.rsp.bvalid && axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
    end
    // Strap is caught after release, once through the synchroniser
    if (!st.boot_done) begin
      next_st.boot_wait = st.boot_wait + 2'h1;
      if (st.boot_wait == BOOT_WAIT) begin
        next_st.boot_done = 1'b1;
        next_st.control = boot_s;
        next_st.act_win = boot_s[WIN_MSB:WIN_LSB];
        next_st.act_per = boot_s[PER_MSB:PER_LSB];
        next_st.lock = boot_s[PER_MSB:PER_LSB] != CODE_OFF;
      end
    end
    if (ctrl_accept) begin
      next_st.control = st.wdata;
      next_st.busy = 1'b1;
      next_st.sync_cnt = 2'h0;
    end
    // Lock write needs the key; zero only takes in debug
    if (wsel && widx == IDX_STATUS && unlock_open) begin
      if (st.wdata[STATUS_LOCK_BIT]) begin
        next_st.lock = 1'b1;
      end else if (debug_s) begin
        next_st.lock = 1'b0;
      end
    end
    if (wsel && widx == IDX_MASK) begin
      next_st.mask = st.wdata[EV_W-1:0];
    end
    if (wsel && widx == IDX_EVENT) begin
      next_st.ev = st.ev & ~st.wdata[EV_W-1:0];
    end
    // Two oscillator ticks stand in for the slow-domain transfer
    if (st.busy && tick) begin
      if (st.sync_cnt == 2'(SYNC_TICKS - 1)) begin
        next_st.busy = 1'b0;
        next_st.act_win = st.control[WIN_MSB:WIN_LSB];
        next_st.act_per = st.control[PER_MSB:PER_LSB];
        next_st.cnt = '0;
        next_st.armed = 1'b0;
        next_st.ev[EV_SYNCED] = 1'b1;
      end else begin
        next_st.sync_cnt = st.sync_cnt + 2'h1;
      end
    end
    // Debug halt clears the count; first period after is plain
    if (debug_s) begin
      next_st.cnt = '0;
      next_st.armed = 1'b0;
    end else if (early) begin
      next_st.rst_req = 1'b1;
      next_st.ev[EV_EARLY] = 1'b1;
    end else if (run && watchdog_restart_instr) begin
      next_st.cnt = '0;
      next_st.armed = st.act_win != CODE_OFF;
    end else if (timeout) begin
      next_st.rst_req = 1'b1;
      next_st.ev[EV_TIMEOUT] = 1'b1;
    end else if (run && tick) begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
    if (st.rsp.rvalid && axi_req.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st.rsp.arready) begin
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = read_word(st, axi_req.araddr[IDX_LSB+2:IDX_LSB]);
      next_st.rsp.rresp = mapped(axi_req.araddr[IDX_LSB+2:IDX_LSB]) ? RESP_OKAY : RESP_SLVERR;
    end
    next_st.rsp.awready = !next_st.aw_ok && !next_st.rsp.bvalid && next_st.boot_done;
    next_st.rsp.wready = !next_st.w_ok && !next_st.rsp.bvalid && next_st.boot_done;
    next_st.rsp.arready = !next_st.rsp.rvalid;
    next_st.irq = |(next_st.ev & next_st.mask);
  end

  // Status and all control state clear to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign axi_rsp = st.rsp;
  assign system_reset_req = st.rst_req;
  assign irq = st.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_lock_freezes;
    st.lock && st.boot_done |=> st.control == $past(st.control);
  endproperty
  a_lock_freezes: assert property (p_lock_freezes) else $error("control changed while locked");

  property p_lock_sticky;
    st.lock && !debug_s |=> st.lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared outside debug");

  property p_boot_lock;
    $rose(st.boot_done) |-> st.lock == (st.control[PER_MSB:PER_LSB] != CODE_OFF);
  endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("boot lock wrong");

  property p_status_reset;
    $past(rst) |-> !st.lock && !st.busy && !st.boot_done;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not zero after reset");

  property p_busy_set;
    ctrl_accept |=> st.busy && st.control == $past(st.wdata);
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not raised by write");

  property p_busy_clear;
    st.busy && tick && st.sync_cnt == 2'(SYNC_TICKS - 1)
      |=> !st.busy && st.act_per == $past(st.control[PER_MSB:PER_LSB]) && st.act_win == $past(st.control[WIN_MSB:WIN_LSB]);
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("transfer did not finish");

  property p_need_key;
    wsel && widx == IDX_CONTROL && !unlock_open |=> st.control == $past(st.control);
  endproperty
  a_need_key: assert property (p_need_key) else $error("control written without key");

  property p_lock_key;
    wsel && widx == IDX_STATUS && !unlock_open |=> st.lock == $past(st.lock);
  endproperty
  a_lock_key: assert property (p_lock_key) else $error("lock written without key");

  property p_timeout;
    timeout |=> system_reset_req && st.ev[EV_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out did not reset");

  property p_restart;
    run && watchdog_restart_instr && !early |=> st.cnt == '0 && !system_reset_req;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear count");

  property p_early;
    early |=> system_reset_req && st.ev[EV_EARLY];
  endproperty
  a_early: assert property (p_early) else $error("early restart not punished");

  property p_irq;
    |(st.ev & st.mask) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_boot_load;
    $rose(st.boot_done) |-> st.control == $past(boot_s);
  endproperty
  a_boot_load: assert property (p_boot_load) else $error("control not taken from strap");

  property p_code_ends;
    (st.act_per == 4'h1 |-> open_len == CNT_W'(8)) and (st.act_per == CODE_MAX |-> open_len == CNT_W'(8192));
  endproperty
  a_code_ends: assert property (p_code_ends) else $error("period code length wrong");

  property p_busy_readonly;
    wsel && widx == IDX_STATUS && !st.busy |=> !st.busy;
  endproperty
  a_busy_readonly: assert property (p_busy_readonly) else $error("busy raised by status write");

  property p_busy_refuse;
    wsel && widx == IDX_CONTROL && st.busy |=> st.control == $past(st.control);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("control written while busy");

  property p_window_arm;
    run && watchdog_restart_instr && !early |=> st.armed == ($past(st.act_win) != CODE_OFF);
  endproperty
  a_window_arm: assert property (p_window_arm) else $error("window arming wrong");

  c_timeout: cover property (timeout ##1 system_reset_req);
  c_early: cover property (early);
  c_sync: cover property (st.busy ##[1:300] !st.busy);
  c_lock_write: cover property (!st.lock && st.boot_done ##1 st.lock);
endmodule

// ===== verification/wdw_watchdog_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module testbench;
  import wdw_pkg::*;
  localparam logic [4:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [4:0] A_STS = {IDX_STATUS, 2'b00};
  localparam logic [4:0] A_EVT = {IDX_EVENT, 2'b00};
  localparam logic [4:0] A_MSK = {IDX_MASK, 2'b00};
  localparam logic [4:0] A_KEY = {IDX_UNLOCK, 2'b00};
  localparam logic [4:0] A_BAD = 5'h14;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wdw_axi_req_t req = '0;
  wdw_axi_rsp_t rsp;
  logic [7:0] boot_config_byte = 8'h00;
  logic low_power_osc = 1'b0;
  logic debug_mode = 1'b0;
  logic watchdog_restart_instr = 1'b0;
  logic system_reset_req;
  logic irq;
  logic osc_run = 1'b1;
  logic [2:0] osc_div = 3'h0;
  logic [3:0] strb = 4'h1;
  int num_errors = 0;
  int n_compared = 0;
  logic [1:0] resp;
  logic [31:0] rdata;
  int cyc;

  always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  // Slow tick source, eight sys_clk per period; stops when osc_run is low
  always @(posedge sys_clk) begin
    if (osc_run) begin
      osc_div <= osc_div + 3'h1;
      low_power_osc <= osc_div[2];
    end
  end

  wdw_watchdog_top wdw_watchdog_top_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .axi_req(req),
    .axi_rsp(rsp),
    .boot_config_byte(boot_config_byte),
    .low_power_osc(low_power_osc),
    .debug_mode(debug_mode),
    .watchdog_restart_instr(watchdog_restart_instr),
    .system_reset_req(system_reset_req),
    .irq(irq)
  );

  task automatic tally_and_finish();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [7:0] boot);
    rst <= 1'b1;
    boot_config_byte <= boot;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
    int t;
    t = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= strb;
    req.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!(req.bready && rsp.bvalid) && t < 100);
    `CHK(t < 100, 1'b1)
    r = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      t++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!(req.rready && rsp.rvalid) && t < 100);
    `CHK(t < 100, 1'b1)
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic prot_wr(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(A_KEY, UNLOCK_KEY, r);
    wr(a, d, r);
    `CHK(r, RESP_OKAY)
  endtask

  task automatic expect_reg(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, {24'h000000, exp})
    `CHK(r, RESP_OKAY)
  endtask

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    int k;
    k = 0;
    do begin
      rd(A_STS, d, r);
      k++;
    end while (d[STATUS_BUSY_BIT] !== 1'b0 && k < 40);
    `CHK(d[STATUS_BUSY_BIT], 1'b0)
  endtask

  task automatic restart();
    watchdog_restart_instr <= 1'b1;
    @(posedge sys_clk);
    watchdog_restart_instr <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial begin
    #(CLK_PERIOD_NS * 30000);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    do_reset(8'h00);
    expect_reg(A_STS, STATUS_RESET);
    expect_reg(A_CTL, 8'h00);
    rd(A_BAD, rdata, resp);
    `CHK(resp, RESP_SLVERR)
    `CHK(rdata, 32'h00000000)
    wr(A_BAD, 8'hff, resp);
    `CHK(resp, RESP_SLVERR)
    // Lane zero disabled: answered, but nothing lands
    strb = 4'h0;
    wr(A_MSK, 8'h07, resp);
    `CHK(resp, RESP_OKAY)
    strb = 4'h1;
    expect_reg(A_MSK, 8'h00);
    wr(A_CTL, 8'h21, resp);
    expect_reg(A_CTL, 8'h00);
    wr(A_STS, 8'h80, resp);
    expect_reg(A_STS, 8'h00);
    prot_wr(A_STS, 8'h01);
    expect_reg(A_STS, 8'h00);
    // Freeze ticks so the busy flag cannot clear under the second write
    osc_run <= 1'b0;
    prot_wr(A_CTL, 8'h01);
    expect_reg(A_STS, 8'h01);
    prot_wr(A_CTL, 8'h02);
    osc_run <= 1'b1;
    wait_idle();
    expect_reg(A_CTL, 8'h01);
    rd(A_EVT, rdata, resp);
    `CHK(rdata[EV_SYNCED], 1'b1)
    // Normal mode, code 1 is eight ticks
    restart();
    repeat (40) @(posedge sys_clk);
    `CHK(system_reset_req, 1'b0)
    restart();
    cyc = 0;
    while (system_reset_req !== 1'b1 && cyc < 200) begin
      @(posedge sys_clk);
      cyc++;
    end
    `CHK(cyc >= 50 && cyc <= 85, 1'b1)
    rd(A_EVT, rdata, resp);
    `CHK(rdata[EV_TIMEOUT], 1'b1)
    // Window mode: closed eight ticks, then open eight ticks
    do_reset(8'h00);
    wr(A_MSK, 8'h02, resp);
    `CHK(irq, 1'b0)
    prot_wr(A_CTL, 8'h11);
    wait_idle();
    expect_reg(A_CTL, 8'h11);
    restart();
    repeat (84) @(posedge sys_clk);
    restart();
    repeat (4) @(posedge sys_clk);
    `CHK(system_reset_req, 1'b0)
    restart();
    repeat (4) @(posedge sys_clk);
    `CHK(system_reset_req, 1'b1)
    rd(A_EVT, rdata, resp);
    `CHK(rdata[EV_EARLY], 1'b1)
    `CHK(irq, 1'b1)
    wr(A_MSK, 8'h00, resp);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    wr(A_MSK, 8'h02, resp);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    wr(A_EVT, 8'h02, resp);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    rd(A_EVT, rdata, resp);
    `CHK(rdata[EV_EARLY], 1'b0)
    // Lock behaviour
    do_reset(8'h00);
    prot_wr(A_STS, 8'h80);
    expect_reg(A_STS, 8'h80);
    prot_wr(A_CTL, 8'h03);
    expect_reg(A_CTL, 8'h00);
    prot_wr(A_STS, 8'h00);
    expect_reg(A_STS, 8'h80);
    debug_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    prot_wr(A_STS, 8'h00);
    expect_reg(A_STS, 8'h00);
    debug_mode <= 1'b0;
    repeat (4) @(posedge sys_clk);
    prot_wr(A_CTL, 8'h03);
    wait_idle();
    expect_reg(A_CTL, 8'h03);
    // Boot strap with a period code locks at start
    do_reset(8'h23);
    expect_reg(A_CTL, 8'h23);
    expect_reg(A_STS, 8'h80);
    tally_and_finish();
  end
endmodule
